// ==== csp_regs.svh ====
// Register offsets, field positions and reset values of the switch block.
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH
`define CSP_OUT_RST   6'h00
`define CSP_CFG_RST   4'h0
`define CSP_TX_RST    8'h00
`define CSP_ADDR_INPUT_COMBINE_LAMP_CFG 2'h1
`define CSP_ADDR_HARDWARE_CONFIG_CMD 2'h2
`define CSP_CFG_AND   3
`define CSP_CTL_BIT   0
`define CSP_LAST_BIT  3'h7
`define CSP_CLR_EDGE  3'h1
`define CSP_DIAG_TAG  2'h0
`define CSP_READ_TAG  1'h1
`endif

// ==== csp_pkg.sv ====
// Types shared by the switch block: serial frame and state records.
`default_nettype none
package csp_pkg;
  typedef struct packed {
    logic       wr;
    logic       bank;
    logic [1:0] addr;
    logic [3:0] data;
  } csp_frame_t;

  typedef struct packed {
    logic [5:0] in_s1;
    logic [5:0] in_s2;
    logic [5:0] ot_s1;
    logic [5:0] ot_s2;
    logic [4:0] dyn_s1;
    logic [4:0] dyn_s2;
    logic       gl_s1;
    logic       gl_s2;
    logic       cs_s1;
    logic       cs_s2;
    logic       rx_s1;
    logic       rx_s2;
    logic       rx_s3;
    logic       clr_s1;
    logic       clr_s2;
    logic       clr_s3;
    logic [5:0] channel_on;
    logic [3:0] cfg;
    logic [5:0] ot_latch;
    logic [5:0] ol_err;
    logic [5:0] drive;
    logic       rd_pend;
    logic       rd_bank;
    logic [1:0] rd_addr;
    logic [7:0] tx_word;
  } csp_core_t;

  typedef struct packed {
    csp_frame_t rx_word;
    logic [6:0] shift;
    logic [6:0] tx_sh;
    logic       diag;
    logic       rx_tgl;
    logic       clr_tgl;
  } csp_link_t;
endpackage : csp_pkg
`default_nettype wire

// ==== csp_switch.sv ====
// Six-channel switch control, thermal latches and serial register port.
`default_nettype none
`include "csp_regs.svh"

// How it works
// - Serial write to bank 0 sets six channel on bits; one bit per channel.
// - Config bit 3 picks OR (0) or AND (1) of input pin and on bit.
// - Config bits 2..0 pick bulb (0) or LED (1) mode for channels 2..0.
// - A tripped over-temperature detector latches its channel off.
// - Restart needs a released detector and a cleared latch.
// - One clear-latch command clears the thermal latch of every channel whose detector has released, all together.
// - Channels 0..4 have dynamic temperature shutdown; channel 5 has none.
// - Dynamic shutdown sets the channel's error flag.
// - Reading the error flag clears it; ongoing shutdown sets it again.
// - Ground loss forces channels 0..4 off; channel 5 keeps its state.
// - Overload flags clear between second and third clock edges of diagnosis.
// - Bit 0 of hardware config write clears latches; zero leaves them.
module csp_switch
  import csp_pkg::*;
(
  // System clock and reset.
  input  wire logic       REF_CLK_IN,
  input  wire logic       RST_B_IN,
  // Serial register port.
  input  wire logic       SCLK_IN,
  input  wire logic       CS_B_IN,
  input  wire logic       SDI_IN,
  output logic            SDO_OUT,
  output logic            SDO_OE_B_OUT,
  // Channel inputs and protection detectors.
  input  wire logic [5:0] CHANNEL_INPUT_PIN_IN,
  input  wire logic [5:0] OT_DETECT_IN,
  input  wire logic [4:0] DYN_SHUT_IN,
  input  wire logic       GND_LOST_IN,
  // Power stage control and status.
  output logic [5:0]      DRIVE_OUT,
  output logic [2:0]      LAMP_TYPE_SELECT_OUT,
  output logic [5:0]      OT_LATCH_OUT
);
  import csp_pkg::*;

  csp_core_t  c;
  csp_core_t  next_c;
  csp_link_t  l;
  csp_link_t  next_l;
  logic [2:0] bit_cnt;
  logic       sdo_q;
  logic       new_frame;
  logic       clr_hit;
  logic       ctl_hit;
  logic [5:0] req;
  logic [5:0] err;
  csp_frame_t f;

  // Link side: bit count restarts whenever the select goes high.
  always_ff @(posedge SCLK_IN or posedge CS_B_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      bit_cnt <= 3'h0;
    end else if (CS_B_IN) begin
      bit_cnt <= 3'h0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  always_comb begin
    next_l = l;
    next_l.shift = {l.shift[5:0], SDI_IN};
    if (bit_cnt == 3'h0) begin
      // The reply word is frozen while the select is low.
      next_l.tx_sh = c.tx_word[6:0];
      next_l.diag = (c.tx_word[7:6] == `CSP_DIAG_TAG);
    end else begin
      next_l.tx_sh = {l.tx_sh[5:0], 1'b0};
    end
    if (bit_cnt == `CSP_CLR_EDGE && l.diag) begin
      next_l.clr_tgl = ~l.clr_tgl;
    end
    if (bit_cnt == `CSP_LAST_BIT) begin
      next_l.rx_word = {l.shift, SDI_IN};
      next_l.rx_tgl = ~l.rx_tgl;
    end
  end

  always_ff @(posedge SCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // Reply bits change on the falling edge so the host samples on the rise.
  always_ff @(negedge SCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= l.tx_sh[6];
    end
  end

  // The first bit must stand before any clock edge of the frame.
  assign SDO_OUT = (bit_cnt == 3'h0) ? c.tx_word[7] : sdo_q;
  assign SDO_OE_B_OUT = CS_B_IN;

  // Core side. The frame word is stable once its toggle has been seen.
  assign f = l.rx_word;
  assign new_frame = c.rx_s2 ^ c.rx_s3;
  assign clr_hit = c.clr_s2 ^ c.clr_s3;
  assign ctl_hit = new_frame && f.wr && f.bank &&
                   f.addr == `CSP_ADDR_HARDWARE_CONFIG_CMD && f.data[`CSP_CTL_BIT];
  assign err = c.ol_err | c.ot_latch;

  always_comb begin
    next_c = c;
    next_c.in_s1 = CHANNEL_INPUT_PIN_IN;
    next_c.in_s2 = c.in_s1;
    next_c.ot_s1 = OT_DETECT_IN;
    next_c.ot_s2 = c.ot_s1;
    next_c.dyn_s1 = DYN_SHUT_IN;
    next_c.dyn_s2 = c.dyn_s1;
    next_c.gl_s1 = GND_LOST_IN;
    next_c.gl_s2 = c.gl_s1;
    next_c.cs_s1 = CS_B_IN;
    next_c.cs_s2 = c.cs_s1;
    next_c.rx_s1 = l.rx_tgl;
    next_c.rx_s2 = c.rx_s1;
    next_c.rx_s3 = c.rx_s2;
    next_c.clr_s1 = l.clr_tgl;
    next_c.clr_s2 = c.clr_s1;
    next_c.clr_s3 = c.clr_s2;
    if (new_frame) begin
      next_c.rd_pend = !f.wr;
      next_c.rd_bank = f.bank;
      next_c.rd_addr = f.addr;
      if (f.wr && !f.bank) begin
        next_c.channel_on = {f.addr, f.data};
      end
      if (f.wr && f.bank && f.addr == `CSP_ADDR_INPUT_COMBINE_LAMP_CFG) begin
        next_c.cfg = f.data;
      end
    end
    // A clear with zero in the command bit leaves the latches alone.
    // A detector that is still tripped keeps its latch set over a clear.
    next_c.ot_latch = (c.ot_latch & ~{6{ctl_hit}}) | c.ot_s2;
    // Flag set wins over the diagnosis clear, so ongoing shutdown shows.
    next_c.ol_err = (c.ol_err & ~{6{clr_hit}}) | {1'b0, c.dyn_s2};
    if (c.cfg[`CSP_CFG_AND]) begin
      req = c.channel_on & c.in_s2;
    end else begin
      req = c.channel_on | c.in_s2;
    end
    // Latch off cannot hold without logic supply here; the stage must.
    next_c.drive = req & ~c.ot_latch & ~{1'b0, c.dyn_s2};
    if (c.gl_s2) begin
      next_c.drive = {c.drive[5], 5'h00};
    end
    if (c.cs_s2) begin
      if (c.rd_pend) begin
        next_c.tx_word = c.rd_bank
          ? {`CSP_READ_TAG, 1'b1, c.rd_addr, c.cfg}
          : {`CSP_READ_TAG, 1'b0, c.channel_on};
      end else begin
        next_c.tx_word = {`CSP_DIAG_TAG, err};
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      c <= '0;
      c.cs_s1 <= 1'b1;
      c.cs_s2 <= 1'b1;
      c.channel_on <= `CSP_OUT_RST;
      c.cfg <= `CSP_CFG_RST;
      c.tx_word <= `CSP_TX_RST;
    end else begin
      c <= next_c;
    end
  end

  assign DRIVE_OUT = c.drive;
  assign LAMP_TYPE_SELECT_OUT = c.cfg[2:0];
  assign OT_LATCH_OUT = c.ot_latch;

  // Checks on the core clock.
  chk_out_write: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    new_frame && f.wr && !f.bank
    |=> c.channel_on == $past({f.addr, f.data}))
    else $error("channel on bits not taken from write");

  chk_input_combine_lamp_cfg_write: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    new_frame && f.wr && f.bank && f.addr == `CSP_ADDR_INPUT_COMBINE_LAMP_CFG
    |=> LAMP_TYPE_SELECT_OUT == $past(f.data[2:0]))
    else $error("lamp mode not taken from config write");

  chk_or_mode: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    !c.cfg[3] && !c.gl_s2 && c.ot_latch == 6'h00 && c.dyn_s2 == 5'h00
    |=> DRIVE_OUT == ($past(c.channel_on) | $past(c.in_s2)))
    else $error("OR combine wrong");

  chk_and_mode: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    c.cfg[3] && !c.gl_s2 && c.ot_latch == 6'h00 && c.dyn_s2 == 5'h00
    |=> DRIVE_OUT == ($past(c.channel_on) & $past(c.in_s2)))
    else $error("AND combine wrong");

  chk_latch_off: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    c.ot_s2 != 6'h00
    |=> ((c.ot_latch & $past(c.ot_s2)) == $past(c.ot_s2))
        ##1 ((DRIVE_OUT & $past(c.ot_s2, 2)) == 6'h00))
    else $error("tripped channel not latched off");

  chk_latch_clear: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    ctl_hit && c.ot_s2 == 6'h00 |=> OT_LATCH_OUT == 6'h00)
    else $error("clear command left a latch set");

  chk_latch_hold: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    !ctl_hit |=> (OT_LATCH_OUT & $past(c.ot_latch)) == $past(c.ot_latch))
    else $error("latch dropped without clear command");

  chk_dyn_err: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    c.dyn_s2 != 5'h00
    |=> ((c.ol_err[4:0] & $past(c.dyn_s2)) == $past(c.dyn_s2))
        && ((DRIVE_OUT[4:0] & $past(c.dyn_s2)) == 5'h00))
    else $error("dynamic shutdown not flagged or not off");

  chk_diag_clear: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    clr_hit && c.dyn_s2 == 5'h00 |=> c.ol_err == 6'h00)
    else $error("overload flags not cleared by diagnosis");

  chk_gnd_loss: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    c.gl_s2 |=> DRIVE_OUT[4:0] == 5'h00 && $stable(DRIVE_OUT[5]))
    else $error("ground loss handling wrong");

  chk_ch5_no_dyn: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    !c.gl_s2 && !c.ot_latch[5] && $past(c.ot_latch[5]) == 1'b0
    |=> DRIVE_OUT[5] == $past(req[5]))
    else $error("channel 5 stopped without cause");

  cov_write_on: cover property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    new_frame && f.wr && !f.bank ##[1:4] DRIVE_OUT != 6'h00);

  cov_latch_cycle: cover property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    OT_LATCH_OUT != 6'h00 ##[1:1000] ctl_hit ##1 OT_LATCH_OUT == 6'h00);

  cov_diag_clear: cover property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    c.ol_err != 6'h00 ##[1:1000] clr_hit);

  cov_gnd_loss: cover property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    DRIVE_OUT[5] ##1 c.gl_s2 [*3]);
endmodule : csp_switch
`default_nettype wire

// ==== csp_host_model.sv ====
// Serial host model that clocks eight-bit frames into the switch block.
`default_nettype none
module csp_host_model (
  // Serial lines.
  output logic      sclk_out,
  output logic      cs_b_out,
  output logic      sdi_out,
  input  wire logic sdo_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk_out = 1'b0;
    cs_b_out = 1'b1;
    sdi_out  = 1'b0;
  end

  // The serial clock only runs inside a frame, as a real host does.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    int i;
    #3;
    cs_b_out = 1'b0;
    #32;
    for (i = 7; i >= 0; i--) begin
      sdi_out = tx[i];
      #32;
      rx[i] = sdo_in;
      sclk_out = 1'b1;
      #32;
      sclk_out = 1'b0;
    end
    // Inverting the last bit keeps stale data from passing as live.
    sdi_out = ~tx[0];
    #32;
    cs_b_out = 1'b1;
    #64;
  endtask : xfer
endmodule : csp_host_model
`default_nettype wire

// ==== csp_switch_tb.sv ====
// Self-checking bench for the channel switch and protection block.
`default_nettype none
module csp_switch_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst_b, sclk, cs_b, sdi, sdo, sdo_oe_b, gnd_lost;
  logic [5:0] pins, ot, drive, latch;
  logic [4:0] dyn;
  logic [2:0] lamp;
  logic [7:0] rx;
  int         fails = 0;
  int         compares = 0;

  csp_switch DUT (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .SCLK_IN(sclk),
    .CS_B_IN(cs_b), .SDI_IN(sdi), .SDO_OUT(sdo),
    .SDO_OE_B_OUT(sdo_oe_b), .CHANNEL_INPUT_PIN_IN(pins),
    .OT_DETECT_IN(ot), .DYN_SHUT_IN(dyn), .GND_LOST_IN(gnd_lost),
    .DRIVE_OUT(drive), .LAMP_TYPE_SELECT_OUT(lamp),
    .OT_LATCH_OUT(latch));
  csp_host_model host (.sclk_out(sclk), .cs_b_out(cs_b), .sdi_out(sdi),
    .sdo_in(sdo));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic test_done();
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // The core applies a frame a few clocks after the eighth serial edge.
  task automatic wr(input logic [7:0] w);
    host.xfer(w, rx);
    cyc(8);
  endtask : wr

  task automatic test_switch();
    wr(8'haa);
    chk("drive", 8'h2a, {2'h0, drive});
    pins = 6'h05;
    cyc(6);
    chk("drive or", 8'h2f, {2'h0, drive});
    wr(8'hdd);
    chk("drive and", 8'h00, {2'h0, drive});
    chk("lamp", 8'h05, {5'h0, lamp});
    pins = 6'h3f;
    cyc(6);
    chk("drive and on", 8'h2a, {2'h0, drive});
    wr(8'h50);
    host.xfer(8'h00, rx);
    chk("cfg read", 8'hdd, rx);
    host.xfer(8'hf0, rx);
    chk("on read", 8'haa, rx);
    wr(8'hd0);
    pins = 6'h00;
    cyc(6);
  endtask : test_switch

  task automatic test_thermal();
    ot = 6'h23;
    cyc(6);
    ot = 6'h20;
    cyc(6);
    chk("latch", 8'h23, {2'h0, latch});
    chk("drive hot", 8'h08, {2'h0, drive});
    host.xfer(8'hf0, rx);
    chk("diag hot", 8'h23, rx);
    wr(8'he0);
    chk("latch kept", 8'h23, {2'h0, latch});
    wr(8'he1);
    chk("latch clr", 8'h20, {2'h0, latch});
    chk("drive part", 8'h0a, {2'h0, drive});
    ot = 6'h00;
    cyc(6);
    chk("latch held", 8'h20, {2'h0, latch});
    wr(8'he1);
    chk("latch none", 8'h00, {2'h0, latch});
    chk("drive back", 8'h2a, {2'h0, drive});
  endtask : test_thermal

  task automatic test_dynamic();
    dyn = 5'h08;
    cyc(6);
    chk("drive dyn", 8'h22, {2'h0, drive});
    host.xfer(8'hf0, rx);
    chk("diag a", 8'h08, rx);
    host.xfer(8'hf0, rx);
    chk("diag b", 8'h08, rx);
    dyn = 5'h00;
    cyc(6);
    chk("drive cool", 8'h2a, {2'h0, drive});
    host.xfer(8'hf0, rx);
    chk("diag c", 8'h08, rx);
    host.xfer(8'hf0, rx);
    chk("diag d", 8'h00, rx);
  endtask : test_dynamic

  task automatic test_ground();
    wr(8'hbf);
    chk("drive all", 8'h3f, {2'h0, drive});
    gnd_lost = 1'b1;
    cyc(6);
    chk("drive gnd", 8'h20, {2'h0, drive});
    gnd_lost = 1'b0;
    cyc(6);
    chk("drive gnd back", 8'h3f, {2'h0, drive});
  endtask : test_ground

  initial begin
    rst_b = 1'b0;
    pins = 6'h00;
    ot = 6'h00;
    dyn = 5'h00;
    gnd_lost = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst_b = 1'b1;
    cyc(4);
    chk("reset", 8'h00, {latch, lamp[1:0]});
    test_switch();
    test_thermal();
    test_dynamic();
    test_ground();
    test_done();
  end

  // Cuts a hang short; the tests need well under twenty microseconds.
  initial begin
    #100000;
    fails++;
    test_done();
  end
endmodule : csp_switch_tb
`default_nettype wire
